// ### rtl/brownout_reset_control.sv
// Reset controller: merges supply detector, watchdog and external pin resets into one system reset.
// Assumes comparator outputs and the pin are asynchronous; watchdog pulse and register port are on clk.
//
// Operation
// - Three supply thresholds, a build option picks which reset and which only flag.
// - The lowest supply detector always resets, whatever the option.
// - High flag, bit 5, reads 1 at or below high threshold, high option only.
// - Middle flag, bit 4, reads 1 at or below the middle threshold.
// - Low option resets below lowest threshold only and disables both flags.
// - Middle option resets below lowest threshold, drives middle flag, high flag disabled.
// - High option resets at or below middle threshold and drives the high flag.
// - Every supply detector reset clears both supply flags.
// - Watchdog overflow causes a full system reset, then normal running resumes.
// - Watchdog reset during low supply holds until supply returns to normal.
// - External pin resets only when the pin option selects the reset function.
// - External pin is active low; the outside party drives it high to run.
// - External pin acts during power-up and running; held low keeps reset.
// - Sequence: wait pin high, initialise registers, warm up oscillator, start at zero.
// - Cause bits: 00 watchdog, 01 reserved, 10 power or supply, 11 external pin.
// - Any reset zeroes arithmetic and supply flags, loads the cause bits, stops execution and clears the counter; interrupt mask and status are kept.
`timescale 1ns/1ps
`default_nettype none

module brownout_reset_control
	import brownout_reset_control_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire supply_detect_option_t supply_option,
	input wire logic reset_pin_enable,
	input wire supply_compare_t supply_compare,
	input wire logic ext_reset_n,
	input wire logic watchdog_overflow,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic sys_reset,
	output logic reg_init,
	output logic osc_warmup,
	output logic cpu_run,
	output logic irq
);

	// Two-flop synchronisers for the comparators and the pin.
	logic [3:0] sync_meta_r;
	logic [3:0] sync_r;
	supply_compare_t cmp_s;
	logic pin_n_s;

	// Sequencer state.
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [`WARMUP_CNT_W-1:0] warm_cnt_r;
	logic [`WARMUP_CNT_W-1:0] warm_cnt_nxt;
	logic wdt_hit_r;
	logic [1:0] cause_pend_r;
	logic [1:0] cause_pend_nxt;

	// Register file.
	logic [1:0] cause_r;
	logic [1:0] cause_nxt;
	logic [2:0] alu_flags_r;
	logic [2:0] alu_flags_nxt;
	logic mid_flag_r;
	logic high_flag_r;
	logic mid_flag_nxt;
	logic high_flag_nxt;
	logic [`EV_WIDTH-1:0] irq_status_r;
	logic [`EV_WIDTH-1:0] irq_status_nxt;
	logic [`EV_WIDTH-1:0] irq_mask_r;
	logic [`EV_WIDTH-1:0] events;

	// Output flops.
	logic sys_reset_r;
	logic reg_init_r;
	logic osc_warmup_r;
	logic cpu_run_r;
	logic irq_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// Decode of the option and the reset sources.
	logic opt_mid_or_high;
	logic opt_high;
	logic supply_reset_src;
	logic pin_reset_src;
	logic any_src;
	logic warm_done;

	// Bus decode.
	logic sel_program_flag_register;
	logic sel_status;
	logic sel_mask;
	logic sel_source;
	logic wr_program_flag_register;
	logic wr_status;
	logic wr_mask;
	logic [7:0] program_flag_register_view;
	logic [7:0] source_view;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] offset);
		addr_hit = (a == offset);
	endfunction : addr_hit

	// Pin is held low and comparators report low supply until the chain has sampled them.
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_meta_r <= 4'h7;
			sync_r <= 4'h7;
		end else begin
			sync_meta_r <= {ext_reset_n, supply_compare};
			sync_r <= sync_meta_r;
		end
	end

	assign cmp_s = supply_compare_t'(sync_r[2:0]);
	assign pin_n_s = sync_r[3];

	assign opt_mid_or_high = (supply_option == supply_detect_option_mid) ||
		(supply_option == supply_detect_option_high);
	assign opt_high = (supply_option == supply_detect_option_high);

	// The low detector needs no enable; the middle one adds a reset only under the high option.
	assign supply_reset_src = cmp_s.below_low || (opt_high && cmp_s.below_mid);
	assign pin_reset_src = reset_pin_enable && !pin_n_s;
	assign any_src = supply_reset_src || pin_reset_src || watchdog_overflow;
	assign warm_done = (warm_cnt_r == `WARMUP_CNT_W'(`WARMUP_CYCLES - 1));

	// Sequencer: a supply or watchdog source forces the hold state from anywhere; the pin forces the pin wait state.
	always_comb begin
		state_nxt = state_r;
		warm_cnt_nxt = warm_cnt_r;
		unique case (state_r)
			ST_HOLD: begin
				if (!supply_reset_src && !watchdog_overflow) begin
					state_nxt = ST_WAIT_PIN;
				end
			end
			ST_WAIT_PIN: begin
				if (!pin_reset_src) begin
					state_nxt = ST_INIT;
				end
			end
			ST_INIT: begin
				state_nxt = ST_WARMUP;
				warm_cnt_nxt = '0;
			end
			ST_WARMUP: begin
				warm_cnt_nxt = warm_cnt_r + `WARMUP_CNT_W'(1);
				if (warm_done) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_HOLD;
			end
		endcase
		if (supply_reset_src || watchdog_overflow) begin
			state_nxt = ST_HOLD;
		end else if (pin_reset_src) begin
			state_nxt = ST_WAIT_PIN;
		end
	end

	// Cause of the pending reset: supply outranks the pin, and the pin (counted only in run) outranks the watchdog.
	always_comb begin
		cause_pend_nxt = cause_pend_r;
		if (supply_reset_src) begin
			cause_pend_nxt = `CAUSE_SUPPLY;
		end else if (pin_reset_src && state_r == ST_RUN) begin
			cause_pend_nxt = `CAUSE_EXTERNAL;
		end else if (watchdog_overflow || (wdt_hit_r && state_r == ST_HOLD &&
				cause_pend_r != `CAUSE_SUPPLY)) begin
			cause_pend_nxt = `CAUSE_WATCHDOG;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_HOLD;
			warm_cnt_r <= '0;
			wdt_hit_r <= 1'b0;
			cause_pend_r <= `CAUSE_SUPPLY;
		end else begin
			state_r <= state_nxt;
			warm_cnt_r <= warm_cnt_nxt;
			wdt_hit_r <= watchdog_overflow;
			cause_pend_r <= cause_pend_nxt;
		end
	end

	// Supply flags follow the comparators when enabled and stay clear during reset.
	always_comb begin
		mid_flag_nxt = opt_mid_or_high && cmp_s.below_mid;
		high_flag_nxt = opt_high && cmp_s.below_high;
		if (state_nxt != ST_RUN) begin
			mid_flag_nxt = 1'b0;
			high_flag_nxt = 1'b0;
		end
	end

	assign sel_program_flag_register = addr_hit(reg_addr, `ADDR_PROGRAM_FLAG);
	assign sel_status = addr_hit(reg_addr, `ADDR_IRQ_STATUS);
	assign sel_mask = addr_hit(reg_addr, `ADDR_IRQ_MASK);
	assign sel_source = addr_hit(reg_addr, `ADDR_SOURCE_STATUS);
	assign wr_program_flag_register = reg_wr && sel_program_flag_register;
	assign wr_status = reg_wr && sel_status;
	assign wr_mask = reg_wr && sel_mask;

	// Cause bits load on release and otherwise keep what software last wrote.
	always_comb begin
		cause_nxt = cause_r;
		if (wr_program_flag_register) begin
			cause_nxt = reg_wdata[`BIT_CAUSE_HI:`BIT_CAUSE_LO];
		end
		if (state_r == ST_INIT) begin
			cause_nxt = cause_pend_r;
		end
	end

	// Arithmetic flags are ordinary storage restored to zero by any reset.
	always_comb begin
		alu_flags_nxt = alu_flags_r;
		if (wr_program_flag_register) begin
			alu_flags_nxt = reg_wdata[`BIT_CARRY:`BIT_ZERO];
		end
		if (state_r != ST_RUN) begin
			alu_flags_nxt = 3'h0;
		end
	end

	// Events: a supply flag rising and the end of a reset sequence.
	assign events = {
		(state_r == ST_WARMUP) && warm_done,
		high_flag_nxt && !high_flag_r,
		mid_flag_nxt && !mid_flag_r
	};

	// A new event wins over a write-one-to-clear in the same cycle.
	assign irq_status_nxt = (irq_status_r & ~(wr_status ? reg_wdata[`EV_WIDTH-1:0] : 3'h0)) | events;

	assign program_flag_register_view = {cause_r, high_flag_r, mid_flag_r, 1'b0, alu_flags_r};
	assign source_view = {3'h0, state_r == ST_RUN, watchdog_overflow, pin_reset_src,
		supply_reset_src, !pin_n_s};

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			if (sel_program_flag_register) begin
				rdata_nxt = program_flag_register_view;
			end else if (sel_status) begin
				rdata_nxt = {5'h00, irq_status_r};
			end else if (sel_mask) begin
				rdata_nxt = {5'h00, irq_mask_r};
			end else if (sel_source) begin
				rdata_nxt = source_view;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cause_r <= `CAUSE_SUPPLY;
			alu_flags_r <= 3'h0;
			mid_flag_r <= 1'b0;
			high_flag_r <= 1'b0;
			irq_status_r <= '0;
			irq_mask_r <= `IRQ_MASK_RESET;
			rdata_r <= 8'h00;
		end else begin
			cause_r <= cause_nxt;
			alu_flags_r <= alu_flags_nxt;
			mid_flag_r <= mid_flag_nxt;
			high_flag_r <= high_flag_nxt;
			irq_status_r <= irq_status_nxt;
			if (wr_mask) begin
				irq_mask_r <= reg_wdata[`EV_WIDTH-1:0];
			end
			rdata_r <= rdata_nxt;
		end
	end

	// Reset and sequence outputs, each from its own flop.
	always_ff @(posedge clk) begin
		if (rst) begin
			sys_reset_r <= 1'b1;
			reg_init_r <= 1'b0;
			osc_warmup_r <= 1'b0;
			cpu_run_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			sys_reset_r <= (state_nxt != ST_RUN);
			reg_init_r <= (state_nxt == ST_INIT);
			osc_warmup_r <= (state_nxt == ST_WARMUP);
			cpu_run_r <= (state_nxt == ST_RUN);
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	assign reg_rdata = rdata_r;
	assign sys_reset = sys_reset_r;
	assign reg_init = reg_init_r;
	assign osc_warmup = osc_warmup_r;
	assign cpu_run = cpu_run_r;
	assign irq = irq_r;

endmodule : brownout_reset_control

`default_nettype wire

// ### rtl/brownout_reset_control_consts.svh
// Register map, field positions, reset values and timing counts of the reset controller.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef BROWNOUT_RESET_CONTROL_CONSTS_SVH
`define BROWNOUT_RESET_CONTROL_CONSTS_SVH

`define ADDR_PROGRAM_FLAG 8'h86
`define ADDR_IRQ_STATUS 8'h88
`define ADDR_IRQ_MASK 8'h89
`define ADDR_SOURCE_STATUS 8'h8A

`define BIT_CAUSE_HI 7
`define BIT_CAUSE_LO 6
`define BIT_HIGH_FLAG 5
`define BIT_MID_FLAG 4
`define BIT_CARRY 2
`define BIT_HALF_CARRY 1
`define BIT_ZERO 0

`define CAUSE_WATCHDOG 2'h0
`define CAUSE_RESERVED 2'h1
`define CAUSE_SUPPLY 2'h2
`define CAUSE_EXTERNAL 2'h3

`define EV_MID_FLAG 0
`define EV_HIGH_FLAG 1
`define EV_RESET_DONE 2
`define EV_WIDTH 3
`define IRQ_MASK_RESET 3'h0

`define CLK_MHZ 50
`define WARMUP_US 64
`define WARMUP_CYCLES (`WARMUP_US * `CLK_MHZ)
`define WARMUP_CNT_W 12

`endif

// ### rtl/brownout_reset_control_pkg.sv
// Types shared by the reset controller and its bench.
// Assumes the constants header sits beside it on the include path.
`include "brownout_reset_control_consts.svh"

package brownout_reset_control_pkg;

	typedef enum logic [1:0] {
		supply_detect_option_low = 2'h0,
		supply_detect_option_mid = 2'h1,
		supply_detect_option_high = 2'h2
	} supply_detect_option_t;

	typedef struct packed {
		logic below_high;
		logic below_mid;
		logic below_low;
	} supply_compare_t;

	typedef enum logic [4:0] {
		ST_HOLD = 5'h01,
		ST_WAIT_PIN = 5'h02,
		ST_INIT = 5'h04,
		ST_WARMUP = 5'h08,
		ST_RUN = 5'h10
	} seq_state_t;

endpackage : brownout_reset_control_pkg

// ### testbench/brownout_reset_control_checker.sv
// Concurrent checks on the ports of the reset controller.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "brownout_reset_control_consts.svh"
module brownout_reset_control_checker
	import brownout_reset_control_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire supply_detect_option_t supply_option,
	input wire logic reset_pin_enable,
	input wire supply_compare_t supply_compare,
	input wire logic ext_reset_n,
	input wire logic watchdog_overflow,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sys_reset,
	input wire logic reg_init,
	input wire logic osc_warmup,
	input wire logic cpu_run,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic flag_rd = reg_rd && reg_addr == `ADDR_PROGRAM_FLAG;
	sequence s_start;
		reg_init ##1 (osc_warmup && !reg_init);
	endsequence
	a_run_excl: assert property (sys_reset != cpu_run)
		else $error("run and reset together");
	a_pin_reset: assert property ((reset_pin_enable && !ext_reset_n) [*4] |-> sys_reset)
		else $error("pin low without reset");
	a_wd_reset: assert property (watchdog_overflow |=> sys_reset)
		else $error("watchdog without reset");
	a_low_reset: assert property (supply_compare.below_low [*4] |-> sys_reset)
		else $error("low supply without reset");
	a_high_opt: assert property ((supply_option == supply_detect_option_high && supply_compare.below_mid) [*4]
		|-> sys_reset)
		else $error("mid supply without reset");
	a_init_step: assert property ($rose(reg_init) |-> s_start)
		else $error("init not followed by warm-up");
	a_run_start: assert property ($rose(cpu_run) |-> $past(osc_warmup))
		else $error("run without warm-up");
	a_stop_flags: assert property (flag_rd && !cpu_run ##1 !cpu_run |-> reg_rdata[5:4] == 2'h0)
		else $error("flags set in reset");
	a_low_flags: assert property (flag_rd && supply_option == supply_detect_option_low
		|=> reg_rdata[5:4] == 2'h0)
		else $error("flags under low option");
	a_mid_flag: assert property (flag_rd && supply_option == supply_detect_option_mid |=> !reg_rdata[5])
		else $error("high flag under mid option");
endmodule : brownout_reset_control_checker
bind brownout_reset_control brownout_reset_control_checker chk (.clk, .rst, .supply_option, .reset_pin_enable,
	.supply_compare, .ext_reset_n, .watchdog_overflow, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.sys_reset, .reg_init, .osc_warmup, .cpu_run, .irq);
`default_nettype wire

// ### testbench/brownout_reset_control_tb.sv
// Self-checking bench of the reset controller.
// Assumes the supervisor model drives the pin and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
`include "brownout_reset_control_consts.svh"
module brownout_reset_control_tb
	import brownout_reset_control_pkg::*;
;
	typedef struct packed {
		supply_detect_option_t opt;
		logic [2:0] cmp;
		logic [1:0] flags;
		logic rst_exp;
	} row_t;
	row_t rows [6] = '{
		'{supply_detect_option_low, 3'h6, 2'h0, 1'b0},
		'{supply_detect_option_low, 3'h1, 2'h0, 1'b1},
		'{supply_detect_option_mid, 3'h6, 2'h1, 1'b0},
		'{supply_detect_option_mid, 3'h4, 2'h0, 1'b0},
		'{supply_detect_option_high, 3'h4, 2'h2, 1'b0},
		'{supply_detect_option_high, 3'h6, 2'h0, 1'b1}
	};
	logic clk = 1'b0;
	logic rst = 1'b1;
	supply_detect_option_t supply_option = supply_detect_option_low;
	logic reset_pin_enable = 1'b1;
	supply_compare_t supply_compare = 3'h0;
	logic watchdog_overflow = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pull_low = 1'b0;
	logic ext_reset_n;
	logic [7:0] reg_rdata;
	logic sys_reset, reg_init, osc_warmup, cpu_run, irq;
	logic [7:0] got;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	brownout_reset_control DUT (.clk, .rst, .supply_option, .reset_pin_enable, .supply_compare, .ext_reset_n,
		.watchdog_overflow, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_reset, .reg_init,
		.osc_warmup, .cpu_run, .irq);
	reset_supervisor_model #(.HOLD(40)) sup (.clk, .rst, .pull_low, .ext_reset_n);
	always #10 clk = ~clk;
	task automatic finish_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 got = reg_rdata;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic reset_to(input supply_detect_option_t o, input logic pe);
		@(posedge clk);
		rst <= 1'b1;
		supply_option <= o;
		reset_pin_enable <= pe;
		supply_compare <= 3'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
	endtask : reset_to
	task automatic wait_run();
		int n;
		n = 0;
		while (cpu_run !== 1'b1 && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({7'h0, cpu_run}, 8'h01);
	endtask : wait_run
	initial begin
		foreach (rows[i]) begin
			reset_to(rows[i].opt, 1'b1);
			wait_run();
			@(posedge clk);
			supply_compare <= supply_compare_t'(rows[i].cmp);
			repeat (8) @(posedge clk);
			#1 chk({7'h0, sys_reset}, {7'h0, rows[i].rst_exp});
			rd(`ADDR_PROGRAM_FLAG);
			chk({6'h0, got[5:4]}, {6'h0, rows[i].flags});
			$display("row %0d done", i);
		end
		reset_to(supply_detect_option_low, 1'b1);
		wait_run();
		rd(`ADDR_PROGRAM_FLAG);
		chk(got, 8'h80);
		wr(`ADDR_PROGRAM_FLAG, 8'h7F);
		rd(`ADDR_PROGRAM_FLAG);
		chk(got, 8'h47);
		rd(8'h00);
		chk(got, 8'h00);
		rd(`ADDR_SOURCE_STATUS);
		chk(got, 8'h10);
		$display("register test done");
		wr(`ADDR_IRQ_MASK, 8'h00);
		rd(`ADDR_IRQ_STATUS);
		chk(got & 8'h04, 8'h04);
		chk({7'h0, irq}, 8'h00);
		wr(`ADDR_IRQ_MASK, 8'h04);
		rd(`ADDR_IRQ_MASK);
		chk(got, 8'h04);
		#1 chk({7'h0, irq}, 8'h01);
		wr(`ADDR_IRQ_STATUS, 8'h04);
		repeat (2) @(posedge clk);
		#1 chk({7'h0, irq}, 8'h00);
		$display("interrupt test done");
		@(posedge clk);
		pull_low <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk({7'h0, sys_reset}, 8'h01);
		pull_low <= 1'b0;
		wait_run();
		rd(`ADDR_PROGRAM_FLAG);
		chk({6'h0, got[7:6]}, 8'h03);
		$display("pin test done");
		@(posedge clk);
		watchdog_overflow <= 1'b1;
		@(posedge clk);
		watchdog_overflow <= 1'b0;
		#1 chk({7'h0, sys_reset}, 8'h01);
		wait_run();
		rd(`ADDR_PROGRAM_FLAG);
		chk({6'h0, got[7:6]}, 8'h00);
		@(posedge clk);
		supply_compare <= 3'h1;
		watchdog_overflow <= 1'b1;
		@(posedge clk);
		watchdog_overflow <= 1'b0;
		repeat (4000) @(posedge clk);
		#1 chk({7'h0, sys_reset}, 8'h01);
		supply_compare <= 3'h0;
		wait_run();
		$display("watchdog test done");
		pull_low <= 1'b1;
		reset_to(supply_detect_option_low, 1'b0);
		wait_run();
		pull_low <= 1'b0;
		$display("pin disable test done");
		finish_test();
	end
endmodule : brownout_reset_control_tb
`default_nettype wire

// ### testbench/reset_supervisor_model.sv
// Supervisor on the external reset pin: holds it low after power-up and on request.
// Assumes the bench clock; the pin is push-pull and never floats.
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor_model #(
	parameter int HOLD = 40
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pull_low,
	output logic ext_reset_n
);
	int cnt = HOLD;
	initial ext_reset_n = 1'b0;
	always @(posedge clk) begin
		if (rst || pull_low) begin
			cnt <= HOLD;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
		ext_reset_n <= !rst && !pull_low && cnt == 0;
	end
endmodule : reset_supervisor_model
`default_nettype wire
